// >>> core/pamux_consts.vh
/*
 Constants of the port A pin-function multiplexer: register offsets,
 reset values, implemented-bit masks and oscillator-select codes.
 Assumes inclusion by bare name from the core design files.
*/
`ifndef PAMUX_CONSTS_VH
`define PAMUX_CONSTS_VH

`define PAMUX_ADDR_W 4
`define PAMUX_OFF_PIN_LEVEL 4'h0
`define PAMUX_OFF_OUT_LATCH 4'h1
`define PAMUX_OFF_DIRECTION 4'h2
`define PAMUX_OFF_ANALOG_SEL 4'h3
`define PAMUX_OFF_CONFIG 4'h4
`define PAMUX_OFF_FN_ENABLE 4'h5
`define PAMUX_RST_DIRECTION 8'hFF
`define PAMUX_RST_LATCH 8'h00
`define PAMUX_RST_ANALOG 8'h2F
`define PAMUX_ANSEL_MASK 8'h2F
`define PAMUX_RST_CONFIG 4'h8
`define PAMUX_RST_FN_ENABLE 8'h00
// Oscillator-select codes
`define PAMUX_OSCILLATOR_SELECT_FIELD_LP 4'h0
`define PAMUX_OSCILLATOR_SELECT_FIELD_XT 4'h1
`define PAMUX_OSCILLATOR_SELECT_FIELD_HS_HI 4'h2
`define PAMUX_OSCILLATOR_SELECT_FIELD_HS_MED 4'h3
`define PAMUX_OSCILLATOR_SELECT_FIELD_EC_HI_CLK 4'h4
`define PAMUX_OSCILLATOR_SELECT_FIELD_EC_HI 4'h5
`define PAMUX_OSCILLATOR_SELECT_FIELD_RC_CLK 4'h6
`define PAMUX_OSCILLATOR_SELECT_FIELD_RC 4'h7
`define PAMUX_OSCILLATOR_SELECT_FIELD_INT_RA6 4'h8
`define PAMUX_OSCILLATOR_SELECT_FIELD_INT_CLK 4'h9
`define PAMUX_OSCILLATOR_SELECT_FIELD_EC_MED_CLK 4'hA
`define PAMUX_OSCILLATOR_SELECT_FIELD_EC_MED 4'hB
`define PAMUX_OSCILLATOR_SELECT_FIELD_EC_LO_CLK 4'hC
`define PAMUX_OSCILLATOR_SELECT_FIELD_EC_LO 4'hD
`define PAMUX_OSCILLATOR_SELECT_FIELD_RC_ALT 4'hE
`define PAMUX_OSCILLATOR_SELECT_FIELD_RC_ALT_CLK 4'hF
// Fn enable register bit positions and the quarter-rate divider phase width
`define PAMUX_FE_SRQ 0
`define PAMUX_FE_SR_LATCH_INVERTED_OUT 1
`define PAMUX_FE_CMP1 2
`define PAMUX_FE_CMP2 3
`define PAMUX_FE_CAPTURE_COMPARE_FIVE 4
`define PAMUX_QUARTER_DIV 2

`endif

// >>> core/pamux_osc_decode.v
/*
 Decodes the 4-bit oscillator-select field into the pin roles of the
 two oscillator pins. Pure combinational; the field is held by the top.
*/
`timescale 1ns/1ps
`include "pamux_consts.vh"
module pamux_osc_decode (
    input wire [3:0] osc_sel,
    output reg internal_osc_mode,
    output reg crystal_mode,
    output reg rc_mode,
    output reg quarter_rate_clock_en
);
    always @* begin
        internal_osc_mode = 1'b0;
        crystal_mode = 1'b0;
        rc_mode = 1'b0;
        quarter_rate_clock_en = 1'b0;
        case (osc_sel)
            `PAMUX_OSCILLATOR_SELECT_FIELD_LP, `PAMUX_OSCILLATOR_SELECT_FIELD_XT, `PAMUX_OSCILLATOR_SELECT_FIELD_HS_HI, `PAMUX_OSCILLATOR_SELECT_FIELD_HS_MED: begin
                crystal_mode = 1'b1;
            end
            `PAMUX_OSCILLATOR_SELECT_FIELD_RC_CLK, `PAMUX_OSCILLATOR_SELECT_FIELD_RC_ALT_CLK: begin
                rc_mode = 1'b1;
                quarter_rate_clock_en = 1'b1;
            end
            `PAMUX_OSCILLATOR_SELECT_FIELD_RC, `PAMUX_OSCILLATOR_SELECT_FIELD_RC_ALT: begin
                rc_mode = 1'b1;
            end
            `PAMUX_OSCILLATOR_SELECT_FIELD_INT_RA6: begin
                internal_osc_mode = 1'b1;
            end
            `PAMUX_OSCILLATOR_SELECT_FIELD_INT_CLK: begin
                internal_osc_mode = 1'b1;
                quarter_rate_clock_en = 1'b1;
            end
            `PAMUX_OSCILLATOR_SELECT_FIELD_EC_HI_CLK, `PAMUX_OSCILLATOR_SELECT_FIELD_EC_MED_CLK, `PAMUX_OSCILLATOR_SELECT_FIELD_EC_LO_CLK: begin
                quarter_rate_clock_en = 1'b1;
            end
            default: begin
                quarter_rate_clock_en = 1'b0;
            end
        endcase
    end
endmodule // pamux_osc_decode

// >>> core/pamux_quarter_clk.v
/*
 Quarter-rate clock generator: a toggle every two enables of the
 oscillator clock gives one quarter of its frequency.
 Assumes osc_tick is a one-cycle enable at the oscillator-input rate.
*/
`timescale 1ns/1ps
`include "pamux_consts.vh"
module pamux_quarter_clk (
    input wire core_clk,
    input wire resetn,
    input wire osc_tick,
    output reg quarter_rate_clock
);
    reg [`PAMUX_QUARTER_DIV-1:0] phase_r;

    always @(posedge core_clk) begin
        if (!resetn) begin
            phase_r <= 2'h0;
            quarter_rate_clock <= 1'b0;
        end else if (osc_tick) begin
            phase_r <= phase_r + 2'h1;
            // Output equals the upper phase bit after the tick: high for two ticks of four
            quarter_rate_clock <= phase_r[1] ^ phase_r[0];
        end
    end
endmodule // pamux_quarter_clk

// >>> core/pamux_top.v
/*
 Port A pin-function multiplexer: registers for latch, direction,
 analog select, oscillator select and peripheral output enables, and
 per-pin priority selection of the pin driver.
 Assumes a one-cycle strobe register port and synchronous pins.
*/
`timescale 1ns/1ps
`include "pamux_consts.vh"
module pamux_top (
    input wire core_clk,
    input wire resetn,
    input wire [`PAMUX_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe,
    input wire sr_latch_true_out,
    input wire sr_latch_inverted_out,
    input wire comparator_one_output,
    input wire comparator_two_output,
    input wire capture_compare_five,
    input wire capture_compare_five_oe,
    input wire osc_tick,
    output reg crystal_drive,
    output reg external_clock_input_fn,
    output reg [7:0] analog_input_en
);
    reg [7:0] output_latch_a_r;
    reg [7:0] direction_a_r;
    reg [7:0] analog_select_a_r;
    reg [3:0] osc_sel_r;
    reg [7:0] fn_enable_r;
    reg [7:0] drv_val_nxt;
    reg [7:0] drv_oe_nxt;
    reg [7:0] dig_in_en_nxt;
    reg [7:0] rdata_nxt;
    wire internal_osc_mode;
    wire crystal_mode;
    wire quarter_rate_clock_en;
    wire quarter_rate_clock;
    wire clock_output_fn;

    pamux_osc_decode u_dec (
        .osc_sel(osc_sel_r),
        .internal_osc_mode(internal_osc_mode),
        .crystal_mode(crystal_mode),
        .rc_mode(),
        .quarter_rate_clock_en(quarter_rate_clock_en)
    );

    pamux_quarter_clk u_qclk (
        .core_clk(core_clk),
        .resetn(resetn),
        .osc_tick(osc_tick),
        .quarter_rate_clock(quarter_rate_clock)
    );

    // Clock output shown on bit 6 whenever not crystal and clockout selected
    assign clock_output_fn = quarter_rate_clock_en & ~crystal_mode;

    // Register writes
    always @(posedge core_clk) begin
        if (!resetn) begin
            output_latch_a_r <= `PAMUX_RST_LATCH;
            direction_a_r <= `PAMUX_RST_DIRECTION;
            analog_select_a_r <= `PAMUX_RST_ANALOG;
            osc_sel_r <= `PAMUX_RST_CONFIG;
            fn_enable_r <= `PAMUX_RST_FN_ENABLE;
        end else if (reg_wr) begin
            case (reg_addr)
                `PAMUX_OFF_PIN_LEVEL, `PAMUX_OFF_OUT_LATCH: begin
                    output_latch_a_r <= reg_wdata;
                end
                `PAMUX_OFF_DIRECTION: begin
                    direction_a_r <= reg_wdata;
                end
                `PAMUX_OFF_ANALOG_SEL: begin
                    analog_select_a_r <= reg_wdata & `PAMUX_ANSEL_MASK;
                end
                `PAMUX_OFF_CONFIG: begin
                    osc_sel_r <= reg_wdata[3:0];
                end
                `PAMUX_OFF_FN_ENABLE: begin
                    fn_enable_r <= reg_wdata & 8'h1F;
                end
                default: begin
                    output_latch_a_r <= output_latch_a_r;
                end
            endcase
        end
    end

    // Per-pin driver selection; the result reaches the pins through a register one cycle later
    always @* begin
        drv_val_nxt = output_latch_a_r;
        drv_oe_nxt = ~direction_a_r;
        dig_in_en_nxt = ~analog_select_a_r;
        // Bits 0-3: latch only, analog select does not block it
        // Bit 4: SR true, comparator 1, capture/compare 5, latch
        if (fn_enable_r[`PAMUX_FE_SRQ]) begin
            drv_val_nxt[4] = sr_latch_true_out;
            drv_oe_nxt[4] = ~direction_a_r[4];
        end else if (fn_enable_r[`PAMUX_FE_CMP1]) begin
            drv_val_nxt[4] = comparator_one_output;
            drv_oe_nxt[4] = ~direction_a_r[4];
        end else if (fn_enable_r[`PAMUX_FE_CAPTURE_COMPARE_FIVE] & capture_compare_five_oe) begin
            drv_val_nxt[4] = capture_compare_five;
            drv_oe_nxt[4] = ~direction_a_r[4];
        end
        // Bit 5: SR inverted, comparator 2, latch; works in analog mode too
        if (fn_enable_r[`PAMUX_FE_SR_LATCH_INVERTED_OUT]) begin
            drv_val_nxt[5] = sr_latch_inverted_out;
            drv_oe_nxt[5] = ~direction_a_r[5];
        end else if (fn_enable_r[`PAMUX_FE_CMP2]) begin
            drv_val_nxt[5] = comparator_two_output;
            drv_oe_nxt[5] = ~direction_a_r[5];
        end
        // Bit 6: crystal output, clock output, released outside internal modes, latch
        if (crystal_mode) begin
            drv_val_nxt[6] = 1'b0;
            drv_oe_nxt[6] = 1'b0;
            dig_in_en_nxt[6] = 1'b0;
        end else if (clock_output_fn) begin
            drv_val_nxt[6] = quarter_rate_clock;
            drv_oe_nxt[6] = 1'b1;
            dig_in_en_nxt[6] = 1'b0;
        end else if (!internal_osc_mode) begin
            drv_val_nxt[6] = 1'b0;
            drv_oe_nxt[6] = 1'b0;
            dig_in_en_nxt[6] = 1'b0;
        end
        // Bit 7: oscillator input wins over the latch outside internal modes
        if (!internal_osc_mode) begin
            drv_val_nxt[7] = 1'b0;
            drv_oe_nxt[7] = 1'b0;
            dig_in_en_nxt[7] = 1'b0;
        end
    end

    // Register reads; data stand in the cycle after the strobe only
    always @* begin
        case (reg_addr)
            `PAMUX_OFF_PIN_LEVEL: rdata_nxt = pin_in & dig_in_en_nxt;
            `PAMUX_OFF_OUT_LATCH: rdata_nxt = output_latch_a_r;
            `PAMUX_OFF_DIRECTION: rdata_nxt = direction_a_r;
            `PAMUX_OFF_ANALOG_SEL: rdata_nxt = analog_select_a_r;
            `PAMUX_OFF_CONFIG: rdata_nxt = {4'h0, osc_sel_r};
            `PAMUX_OFF_FN_ENABLE: rdata_nxt = fn_enable_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Pins are registered so every output comes from a flip-flop
    always @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            crystal_drive <= 1'b0;
            external_clock_input_fn <= 1'b0;
            analog_input_en <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
            pin_out <= drv_val_nxt;
            pin_oe <= drv_oe_nxt;
            crystal_drive <= crystal_mode;
            external_clock_input_fn <= ~internal_osc_mode;
            analog_input_en <= analog_select_a_r;
        end
    end
endmodule // pamux_top

// >>> testbench/pamux_monitor.sv
/*
 Checker of the pamux_top ports: register read shape, oscillator pin roles.
 Assumes binding to pamux_top and the shared constants header.
*/
`timescale 1ns/1ps
`include "pamux_consts.vh"
module pamux_monitor (
    input wire core_clk,
    input wire resetn,
    input wire [`PAMUX_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire crystal_drive,
    input wire external_clock_input_fn,
    input wire [7:0] analog_input_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_unmapped_zero: assert property (
        reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00) else $error("Unmapped read not zero");
    a_ana_rd_bits: assert property (
        reg_rd && reg_addr == `PAMUX_OFF_ANALOG_SEL |=> (reg_rdata & 8'hD0) == 8'h00)
        else $error("Analog select unused bits set");
    a_cfg_rd_bits: assert property (
        reg_rd && reg_addr == `PAMUX_OFF_CONFIG |=> reg_rdata[7:4] == 4'h0)
        else $error("Oscillator select upper bits set");
    a_ana_en_bits: assert property (
        (analog_input_en & 8'hD0) == 8'h00) else $error("Analog enable on unimplemented pin");
    a_ana_en_copy: assert property (
        reg_wr && reg_addr == `PAMUX_OFF_ANALOG_SEL ##1 !reg_wr
        |=> analog_input_en == ($past(reg_wdata, 2) & `PAMUX_ANSEL_MASK))
        else $error("Analog enable does not follow write");
    a_latch_low: assert property (
        reg_wr && reg_addr <= `PAMUX_OFF_OUT_LATCH ##1 !reg_wr
        |=> pin_out[3:0] == $past(reg_wdata[3:0], 2)) else $error("Low pins not latch");
    a_xtal_b6_off: assert property (
        crystal_drive |-> !pin_oe[6]) else $error("Bit 6 driven in crystal mode");
    a_xtal_b7_in: assert property (
        crystal_drive |-> external_clock_input_fn) else $error("Bit 7 not clock input");
    a_ext_b7_off: assert property (
        external_clock_input_fn |-> !pin_oe[7]) else $error("Bit 7 driven in external mode");
endmodule // pamux_monitor

bind pamux_top pamux_monitor u_pamux_monitor (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe), .crystal_drive(crystal_drive),
    .external_clock_input_fn(external_clock_input_fn), .analog_input_en(analog_input_en));

// >>> testbench/pamux_pin_load.sv
/*
 Board-side load of the eight port A pins.
 Assumes the bench sets the released-pin level; there are no pull resistors.
*/
`timescale 1ns/1ps
module pamux_pin_load (
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] board_level,
    output wire [7:0] pin_in
);
    // Released pins show the board level, never the last driven value
    assign pin_in = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule // pamux_pin_load

// >>> testbench/tb_top.sv
/*
 Self-checking bench of pamux_top: registers, priority chains, oscillator modes.
 Assumes a 200 MHz clock and the board load model.
*/
`timescale 1ns/1ps
`include "pamux_consts.vh"
module tb_top;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg rd_d = 1'b0;
    reg [5:0] per = 6'h00;
    reg osc_tick = 1'b1;
    reg tick_half = 1'b0;
    reg [7:0] board = 8'h00;
    reg [7:0] d;
    reg [7:0] q[$];
    reg e4, e5, p0;
    wire [7:0] reg_rdata, pin_in, pin_out, pin_oe, analog_input_en;
    wire crystal_drive, external_clock_input_fn;
    integer seed = 59;
    integer n_fail = 0;
    integer num_checks = 0;
    integer i;
    always #2.5 core_clk = ~core_clk;
    pamux_top u_pamux_top (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .sr_latch_true_out(per[0]),
        .sr_latch_inverted_out(per[1]), .comparator_one_output(per[2]),
        .comparator_two_output(per[3]), .capture_compare_five(per[4]),
        .capture_compare_five_oe(per[5]), .osc_tick(osc_tick), .crystal_drive(crystal_drive),
        .external_clock_input_fn(external_clock_input_fn), .analog_input_en(analog_input_en));
    pamux_pin_load u_pamux_pin_load (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_level(board), .pin_in(pin_in));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // Trailing idle edge keeps a strobe from being lowered and raised at once
    task wr(input [3:0] a, input [7:0] v);
    begin
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge core_clk); reg_wr <= 1'b0; @(posedge core_clk);
    end
    endtask
    task rd(input [3:0] a, input [7:0] e);
    begin
        q.push_back(e); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge core_clk); reg_rd <= 1'b0; @(posedge core_clk);
    end
    endtask
    task settle;
        repeat (3) @(posedge core_clk);
    endtask
    // Half-rate oscillator ticks exercise the divider with real enable gaps
    always @(posedge core_clk) begin
        if (tick_half) osc_tick <= ~osc_tick;
    end
    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata, q.pop_front());
    end
    initial begin
        #20000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(4'h1, 8'h00); rd(4'h2, 8'hFF); rd(4'h5, 8'h00);
        rd(4'h3, 8'h2F); rd(4'h4, 8'h08); rd(4'hF, 8'h00);
        wr(4'h3, 8'hFF); rd(4'h3, 8'h2F);
        chk(analog_input_en, 8'h2F);
        d = $random(seed);
        wr(4'h2, 8'h00); wr(4'h1, d); rd(4'h1, d);
        settle;
        chk(pin_oe, 8'hFF);
        chk(pin_out, d);
        for (i = 0; i < 32; i = i + 1) begin
            per <= $random(seed);
            wr(4'h5, i[7:0]);
            settle;
            e4 = i[0] ? per[0] : i[2] ? per[2] : (i[4] && per[5]) ? per[4] : d[4];
            e5 = i[1] ? per[1] : i[3] ? per[3] : d[5];
            chk(pin_out[5:0], {e5, e4, d[3:0]});
        end
        wr(4'h5, 8'h00); wr(4'h2, 8'hFF); board <= $random(seed); settle;
        chk(pin_oe, 8'h00);
        rd(4'h0, board & 8'hD0);
        wr(4'h2, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            wr(4'h4, i[7:0]); rd(4'h4, i[7:0]);
            settle;
            e4 = (i == 8) || (i == 9);
            e5 = (i == 8) || ((16'h9650 >> i) & 1);
            chk(pin_oe[7:6], {e4, e5});
            chk(crystal_drive, i < 4);
            chk(external_clock_input_fn, !e4);
        end
        // Ticks run every cycle, so the quarter clock has a four-cycle period
        wr(4'h4, 8'h06); settle; p0 = pin_out[6];
        repeat (2) @(posedge core_clk); chk(pin_out[6], !p0);
        repeat (2) @(posedge core_clk); chk(pin_out[6], p0);
        // Ticks every other cycle stretch the period to eight cycles
        tick_half <= 1'b1;
        settle; settle; settle; p0 = pin_out[6];
        repeat (4) @(posedge core_clk); chk(pin_out[6], !p0);
        repeat (4) @(posedge core_clk); chk(pin_out[6], p0);
        end_of_test;
    end
endmodule // tb_top
